/* motion_irq_params.svh */
// Constants for the tap, orientation and wake interrupt block.
// Assumes an 8-bit register space reached over a plain strobe port.
`ifndef MOTION_IRQ_PARAMS_SVH
`define MOTION_IRQ_PARAMS_SVH

// Register offsets.
`define ADDR_GEN1_DURATION 8'h33
`define ADDR_GEN2_CONFIG 8'h34
`define ADDR_GEN2_SOURCE 8'h35
`define ADDR_GEN2_THRESHOLD 8'h36
`define ADDR_GEN2_DURATION 8'h37
`define ADDR_TAP_CONFIG 8'h38
`define ADDR_TAP_SOURCE 8'h39
`define ADDR_TAP_THRESHOLD 8'h3A
`define ADDR_TAP_TIME_LIMIT 8'h3B
`define ADDR_TAP_LATENCY 8'h3C
`define ADDR_TAP_WINDOW 8'h3D
`define ADDR_WAKE_THRESHOLD 8'h3E
`define ADDR_WAKE_DURATION 8'h3F
`define ADDR_IRQ_CONTROL 8'h40

// Field positions.
`define CFG_AND_OR_BIT 7
`define CFG_SIX_DIR_BIT 6
`define SRC_ACTIVE_BIT 6
`define TAP_LATCH_BIT 7
`define CTRL_GEN2_LATCH_BIT 0
`define CTRL_FOUR_DIR_BIT 1
`define CTRL_POLARITY_BIT 2

// Reset value shared by every register.
`define REG_RESET 8'h00

// Return-to-sleep time is (8*N+1) samples.
`define WAKE_STEP 11'h008
`define WAKE_OFFSET 11'h001

`endif

/* motion_irq_pkg.sv */
// Types for the tap, orientation and wake interrupt block.
// Assumes motion_irq_params.svh supplies all numeric constants.
package motion_irq_pkg;

    // One register access from the host port.
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    // One acceleration sample, high bytes of X, Y and Z, two's complement.
    typedef struct packed {
        logic [7:0] z;
        logic [7:0] y;
        logic [7:0] x;
    } accel_sample_t;

    // Tap detector states, Gray coded along idle-first-quiet-gap-second.
    typedef enum logic [2:0] {
        TAP_IDLE = 3'h0,
        TAP_FIRST = 3'h1,
        TAP_QUIET = 3'h3,
        TAP_GAP = 3'h2,
        TAP_SECOND = 3'h6,
        TAP_HOLDOFF = 3'h4
    } tap_state_t;

endpackage : motion_irq_pkg

/* motion_irq.sv */
// Second inertial generator, tap detector and wake logic of an accelerometer.
// Assumes one sample_valid_i pulse per output sample and a host on the strobe port.
// What this block does
// RL1 - Generator duration registers: 7-bit count, bit 7 zero
// RL2 - Event needs condition held for duration count
// RL3 - Combine and six-direction bits pick mode
// RL4 - Movement mode pulses on entering known zone
// RL5 - Position mode asserts while in known zone
// RL6 - Per-axis above/below enables request events
// RL7 - Generator threshold is 7 bits, reset zero
// RL8 - Source reports active and per-axis flags
// RL9 - Source read clears active, pin, latch
// RL10 - Generator config writes only accepted after boot
// RL11 - Per-axis single and double tap enables
// RL12 - Tap source: active, double, single, sign, axes
// RL13 - Unlatched tap interrupt lasts latency window
// RL14 - Latched tap interrupt holds until read
// RL15 - Tap threshold 7 bits, latch in bit 7
// RL16 - Tap limit, latency and window timing fields
// RL17 - Wake threshold 7 bits, used in low power
// RL18 - Wake duration gives (8N+1) sample periods
// RL19 - Generator latch keeps flags until read
// RL20 - Four-direction restricts orientation to X,Y
// RL21 - Polarity bit inverts both interrupt pins
// RL22 - Duration counter restarts when condition drops
// RL23 - Zero duration recognises on first sample
`timescale 1ns/1ns
`include "motion_irq_params.svh"

module motion_irq (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic clk_en_i,
    input wire motion_irq_pkg::reg_req_t req_i,
    output logic [7:0] rd_data_o,
    input wire logic boot_done_i,
    input wire logic low_power_i,
    input wire logic sample_valid_i,
    input wire motion_irq_pkg::accel_sample_t sample_i,
    output logic second_irq_pin_o,
    output logic tap_irq_pin_o,
    output logic awake_o
);

    // Register storage; bit 7 of masked registers is never stored as one.
    logic [7:0] gen1_event_duration;
    logic [7:0] gen2_event_config;
    logic [7:0] gen2_event_threshold;
    logic [7:0] gen2_event_duration;
    logic [7:0] tap_config;
    logic [7:0] tap_threshold;
    logic [7:0] tap_time_limit;
    logic [7:0] tap_latency;
    logic [7:0] tap_window;
    logic [7:0] wake_threshold;
    logic [7:0] wake_duration;
    logic [7:0] irq_control;

    // Status held by the generator and tap detector.
    logic [7:0] gen2_event_source;
    logic [7:0] tap_source;

    // Decoded control bits.
    logic gen2_latch;
    logic gen2_four_direction;
    logic polarity;
    logic tap_latch;
    logic and_or_select;
    logic six_direction_mode;
    logic [5:0] gen2_enables;

    // A sample step only counts while the clock enable is high.
    logic step;
    logic wr_en;
    logic rd_en;

    assign step = clk_en_i & sample_valid_i;
    assign wr_en = clk_en_i & req_i.wr;
    assign rd_en = clk_en_i & req_i.rd;
    assign gen2_latch = irq_control[`CTRL_GEN2_LATCH_BIT];
    assign gen2_four_direction = irq_control[`CTRL_FOUR_DIR_BIT];
    assign polarity = irq_control[`CTRL_POLARITY_BIT];
    assign tap_latch = tap_threshold[`TAP_LATCH_BIT];
    assign and_or_select = gen2_event_config[`CFG_AND_OR_BIT];
    assign six_direction_mode = gen2_event_config[`CFG_SIX_DIR_BIT];
    assign gen2_enables = gen2_event_config[5:0];

    // Per-axis magnitude and threshold comparisons.
    logic [2:0] axis_neg;
    logic [2:0] gen2_above;
    logic [2:0] tap_above;
    logic [2:0] wake_above;

    // One comparator set per axis; -128 maps to magnitude 128, above any threshold.
    generate
        for (genvar i = 0; i < 3; i++)
        begin : g_axis
            logic [7:0] raw;
            logic [7:0] mag;
            assign raw = sample_i[8*i +: 8];
            assign axis_neg[i] = raw[7];
            assign mag = raw[7] ? (8'h00 - raw) : raw;
            // RL6 above compare
            assign gen2_above[i] = mag > {1'b0, gen2_event_threshold[6:0]};
            assign tap_above[i] = mag > {1'b0, tap_threshold[6:0]};
            assign wake_above[i] = mag > {1'b0, wake_threshold[6:0]};
        end
    endgenerate

    // Plain events in source order {zh, zl, yh, yl, xh, xl}.
    logic [5:0] plain_events;
    // Orientation zone in the same order, zero while the zone is unknown.
    logic [5:0] zone_events;
    logic [2:0] zone_axes;
    logic zone_known;
    logic gen2_condition;
    logic [5:0] gen2_flags_now;

    // RL6 above and below events
    assign plain_events = {gen2_above[2], ~gen2_above[2], gen2_above[1], ~gen2_above[1],
                           gen2_above[0], ~gen2_above[0]};

    // RL20 drop Z in four-direction
    assign zone_axes = gen2_four_direction ? {1'b0, gen2_above[1:0]} : gen2_above;
    assign zone_known = (zone_axes == 3'h1) || (zone_axes == 3'h2) || (zone_axes == 3'h4);
    assign zone_events = zone_known ?
        {zone_axes[2] & ~axis_neg[2], zone_axes[2] & axis_neg[2],
         zone_axes[1] & ~axis_neg[1], zone_axes[1] & axis_neg[1],
         zone_axes[0] & ~axis_neg[0], zone_axes[0] & axis_neg[0]} : 6'h00;

    // Combined condition per mode; AND with no enables never fires.
    always_comb
    begin
        // RL3 mode select
        case ({and_or_select, six_direction_mode})
            2'b00: gen2_condition = |(plain_events & gen2_enables);
            2'b10: gen2_condition = (gen2_enables != 6'h00) &&
                                    ((plain_events & gen2_enables) == gen2_enables);
            2'b01: gen2_condition = |(zone_events & gen2_enables);
            2'b11: gen2_condition = |(zone_events & gen2_enables);
            default: gen2_condition = 1'b0;
        endcase
        gen2_flags_now = six_direction_mode ? (zone_events & gen2_enables)
                                            : (plain_events & gen2_enables);
    end

    // Consecutive samples that met the condition, saturating at 127.
    logic [6:0] gen2_count;
    logic gen2_hit;
    logic gen2_hit_prev;
    logic gen2_event_now;

    // RL2 duration check
    // RL23 zero means first sample
    assign gen2_hit = gen2_condition && (gen2_count >= gen2_event_duration[6:0]);
    // RL4 rising edge of zone
    // RL5 level while in zone
    assign gen2_event_now = (six_direction_mode && !and_or_select) ?
                            (gen2_hit && !gen2_hit_prev) : gen2_hit;

    // Duration counter advances once per sample.
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            gen2_count <= 7'h00;
            gen2_hit_prev <= 1'b0;
        end
        else if (step)
        begin
            // RL22 count or restart
            if (!gen2_condition)
                gen2_count <= 7'h00;
            else if (gen2_count != 7'h7F)
                gen2_count <= gen2_count + 7'h01;
            gen2_hit_prev <= gen2_hit;
        end
    end

    // Generator source register; a new sample wins over a read clear.
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            gen2_event_source <= `REG_RESET;
        else if (step)
        begin
            // RL19 latched accumulates
            if (gen2_latch && !(rd_en && req_i.addr == `ADDR_GEN2_SOURCE))
                gen2_event_source <= gen2_event_source |
                    {1'b0, gen2_event_now, gen2_event_now ? gen2_flags_now : 6'h00};
            else
                // RL8 fresh flags, bit 7 zero
                gen2_event_source <= {1'b0, gen2_event_now,
                                      gen2_event_now ? gen2_flags_now : 6'h00};
        end
        else if (rd_en && req_i.addr == `ADDR_GEN2_SOURCE)
        begin
            // RL9 read clears
            if (gen2_latch)
                gen2_event_source <= `REG_RESET;
            else
                gen2_event_source[`SRC_ACTIVE_BIT] <= 1'b0;
        end
    end

    // Tap detector state.
    motion_irq_pkg::tap_state_t tap_state;
    logic [7:0] tap_count;
    logic [2:0] tap_axes;
    logic tap_sign;
    logic [2:0] tap_axis_en;
    logic tap_peak;
    logic tap_report;
    logic tap_report_double;
    logic [7:0] tap_hold;

    // RL11 per-axis enables
    assign tap_axis_en = {tap_config[5] | tap_config[4], tap_config[3] | tap_config[2],
                          tap_config[1] | tap_config[0]};
    assign tap_peak = |(tap_above & tap_axis_en);

    // Tap sequencing per sample; the report is a one-cycle strobe.
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            tap_state <= motion_irq_pkg::TAP_IDLE;
            tap_count <= 8'h00;
            tap_axes <= 3'h0;
            tap_sign <= 1'b0;
            tap_report <= 1'b0;
            tap_report_double <= 1'b0;
        end
        else if (clk_en_i)
        begin
            tap_report <= 1'b0;
            if (sample_valid_i)
            begin
                // RL16 timing fields
                case (tap_state)
                    motion_irq_pkg::TAP_IDLE:
                    begin
                        if (tap_peak)
                        begin
                            tap_state <= motion_irq_pkg::TAP_FIRST;
                            tap_count <= 8'h00;
                            tap_axes <= tap_above & tap_axis_en;
                            // RL12 sign capture
                            tap_sign <= |(tap_above & tap_axis_en & axis_neg);
                        end
                    end
                    motion_irq_pkg::TAP_FIRST:
                    begin
                        if (tap_peak && tap_count >= {1'b0, tap_time_limit[6:0]})
                            tap_state <= motion_irq_pkg::TAP_HOLDOFF;
                        else if (tap_peak)
                            tap_count <= tap_count + 8'h01;
                        else
                        begin
                            // A short peak is a single tap candidate.
                            tap_report <= |(tap_axes & {tap_config[4], tap_config[2],
                                                        tap_config[0]});
                            tap_report_double <= 1'b0;
                            tap_state <= motion_irq_pkg::TAP_QUIET;
                            tap_count <= 8'h00;
                        end
                    end
                    motion_irq_pkg::TAP_QUIET:
                    begin
                        if (tap_count >= tap_latency)
                        begin
                            tap_state <= motion_irq_pkg::TAP_GAP;
                            tap_count <= 8'h00;
                        end
                        else
                            tap_count <= tap_count + 8'h01;
                    end
                    motion_irq_pkg::TAP_GAP:
                    begin
                        if (tap_peak)
                        begin
                            tap_state <= motion_irq_pkg::TAP_SECOND;
                            tap_count <= 8'h00;
                        end
                        else if (tap_count >= tap_window)
                            tap_state <= motion_irq_pkg::TAP_IDLE;
                        else
                            tap_count <= tap_count + 8'h01;
                    end
                    motion_irq_pkg::TAP_SECOND:
                    begin
                        if (tap_peak && tap_count >= {1'b0, tap_time_limit[6:0]})
                            tap_state <= motion_irq_pkg::TAP_HOLDOFF;
                        else if (tap_peak)
                            tap_count <= tap_count + 8'h01;
                        else
                        begin
                            tap_report <= |(tap_axes & {tap_config[5], tap_config[3],
                                                        tap_config[1]});
                            tap_report_double <= 1'b1;
                            tap_state <= motion_irq_pkg::TAP_IDLE;
                        end
                    end
                    // Too long a peak is no tap; wait for release before rearming.
                    motion_irq_pkg::TAP_HOLDOFF:
                    begin
                        if (!tap_peak)
                            tap_state <= motion_irq_pkg::TAP_IDLE;
                    end
                    default: tap_state <= motion_irq_pkg::TAP_IDLE;
                endcase
            end
        end
    end

    // Tap source and its hold timer; a report wins over a read or expiry.
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            tap_source <= `REG_RESET;
            tap_hold <= 8'h00;
        end
        else if (clk_en_i)
        begin
            if (tap_report)
            begin
                // RL12 source layout
                tap_source <= {1'b0, 1'b1, tap_report_double, ~tap_report_double,
                               tap_sign, tap_axes};
                tap_hold <= tap_latency;
            end
            else if (tap_latch)
            begin
                // RL14 hold until read
                if (req_i.rd && req_i.addr == `ADDR_TAP_SOURCE)
                    tap_source <= `REG_RESET;
            end
            else if (sample_valid_i && tap_source[`SRC_ACTIVE_BIT])
            begin
                // RL13 latency window only
                if (tap_hold == 8'h00)
                    tap_source[`SRC_ACTIVE_BIT] <= 1'b0;
                else
                    tap_hold <= tap_hold - 8'h01;
            end
        end
    end

    // Wake logic: awake on activity, back to sleep after (8N+1) quiet samples.
    logic [10:0] wake_count;
    logic [10:0] wake_limit;

    // RL18 (8N+1) samples
    assign wake_limit = `WAKE_STEP * {3'h0, wake_duration} + `WAKE_OFFSET;

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            awake_o <= 1'b1;
            wake_count <= 11'h000;
        end
        else if (clk_en_i && !low_power_i)
        begin
            // Outside low power the device stays awake.
            awake_o <= 1'b1;
            wake_count <= 11'h000;
        end
        else if (step)
        begin
            // RL17 low-power threshold
            if (|wake_above)
            begin
                awake_o <= 1'b1;
                wake_count <= 11'h000;
            end
            else if (awake_o && wake_count + 11'h001 >= wake_limit)
                awake_o <= 1'b0;
            else if (awake_o)
                wake_count <= wake_count + 11'h001;
        end
    end

    // Register writes; masked bits are stored as zero.
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            gen1_event_duration <= `REG_RESET;
            gen2_event_config <= `REG_RESET;
            gen2_event_threshold <= `REG_RESET;
            gen2_event_duration <= `REG_RESET;
            tap_config <= `REG_RESET;
            tap_threshold <= `REG_RESET;
            tap_time_limit <= `REG_RESET;
            tap_latency <= `REG_RESET;
            tap_window <= `REG_RESET;
            wake_threshold <= `REG_RESET;
            wake_duration <= `REG_RESET;
            irq_control <= `REG_RESET;
        end
        else if (wr_en)
        begin
            case (req_i.addr)
                // RL1 bit 7 zero
                `ADDR_GEN1_DURATION: gen1_event_duration <= {1'b0, req_i.wdata[6:0]};
                // RL10 only after boot
                `ADDR_GEN2_CONFIG:
                begin
                    if (boot_done_i)
                        gen2_event_config <= req_i.wdata;
                end
                // RL7 seven-bit threshold
                `ADDR_GEN2_THRESHOLD: gen2_event_threshold <= {1'b0, req_i.wdata[6:0]};
                `ADDR_GEN2_DURATION: gen2_event_duration <= {1'b0, req_i.wdata[6:0]};
                `ADDR_TAP_CONFIG: tap_config <= {2'h0, req_i.wdata[5:0]};
                // RL15 latch and threshold
                `ADDR_TAP_THRESHOLD: tap_threshold <= req_i.wdata;
                `ADDR_TAP_TIME_LIMIT: tap_time_limit <= {1'b0, req_i.wdata[6:0]};
                `ADDR_TAP_LATENCY: tap_latency <= req_i.wdata;
                `ADDR_TAP_WINDOW: tap_window <= req_i.wdata;
                `ADDR_WAKE_THRESHOLD: wake_threshold <= {1'b0, req_i.wdata[6:0]};
                `ADDR_WAKE_DURATION: wake_duration <= req_i.wdata;
                `ADDR_IRQ_CONTROL: irq_control <= {5'h00, req_i.wdata[2:0]};
                // Source registers and unmapped addresses ignore writes.
                default: irq_control <= irq_control;
            endcase
        end
    end

    // Read data registered one cycle after the strobe; unmapped reads give zero.
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            rd_data_o <= 8'h00;
        else if (rd_en)
        begin
            case (req_i.addr)
                `ADDR_GEN1_DURATION: rd_data_o <= gen1_event_duration;
                `ADDR_GEN2_CONFIG: rd_data_o <= gen2_event_config;
                `ADDR_GEN2_SOURCE: rd_data_o <= gen2_event_source;
                `ADDR_GEN2_THRESHOLD: rd_data_o <= gen2_event_threshold;
                `ADDR_GEN2_DURATION: rd_data_o <= gen2_event_duration;
                `ADDR_TAP_CONFIG: rd_data_o <= tap_config;
                `ADDR_TAP_SOURCE: rd_data_o <= tap_source;
                `ADDR_TAP_THRESHOLD: rd_data_o <= tap_threshold;
                `ADDR_TAP_TIME_LIMIT: rd_data_o <= tap_time_limit;
                `ADDR_TAP_LATENCY: rd_data_o <= tap_latency;
                `ADDR_TAP_WINDOW: rd_data_o <= tap_window;
                `ADDR_WAKE_THRESHOLD: rd_data_o <= wake_threshold;
                `ADDR_WAKE_DURATION: rd_data_o <= wake_duration;
                `ADDR_IRQ_CONTROL: rd_data_o <= irq_control;
                default: rd_data_o <= 8'h00;
            endcase
        end
    end

    // Pins follow the active flags directly, so a clear shows in the same cycle.
    // RL21 polarity inversion
    assign second_irq_pin_o = gen2_event_source[`SRC_ACTIVE_BIT] ^ polarity;
    assign tap_irq_pin_o = tap_source[`SRC_ACTIVE_BIT] ^ polarity;

endmodule : motion_irq

/* motion_irq_properties.sv */
// Port checker for motion_irq.
// Assumes it is bound onto motion_irq.
`timescale 1ns/1ns
`include "motion_irq_params.svh"
module motion_irq_properties (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic clk_en_i,
    input wire motion_irq_pkg::reg_req_t req_i,
    input wire logic [7:0] rd_data_o,
    input wire logic boot_done_i,
    input wire logic low_power_i,
    input wire logic sample_valid_i,
    input wire logic second_irq_pin_o,
    input wire logic awake_o
);
    // Shadow copies of the pin polarity and the accepted config value.
    logic pol;
    logic [7:0] cfg;
    always_ff @(posedge clk_i or negedge arst_n_i)
        if (!arst_n_i)
            {pol, cfg} <= 9'h000;
        else if (clk_en_i && req_i.wr && req_i.addr == `ADDR_IRQ_CONTROL)
            pol <= req_i.wdata[2];
        else if (clk_en_i && req_i.wr && req_i.addr == `ADDR_GEN2_CONFIG && boot_done_i)
            cfg <= req_i.wdata;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    sequence s_rd(a);
        clk_en_i && req_i.rd && req_i.addr == a;
    endsequence
    property p_hold; !(clk_en_i && req_i.rd) |=> $stable(rd_data_o); endproperty
    property p_unm; clk_en_i && req_i.rd && req_i.addr > 8'h40 |=> rd_data_o == 8'h00; endproperty
    property p_dur; s_rd(`ADDR_GEN2_DURATION) |=> !rd_data_o[7]; endproperty
    property p_src; s_rd(`ADDR_GEN2_SOURCE) |=> !rd_data_o[7]; endproperty
    property p_clr; s_rd(`ADDR_GEN2_SOURCE) ##0 !sample_valid_i |=> second_irq_pin_o == pol;
    endproperty
    property p_cfg; s_rd(`ADDR_GEN2_CONFIG) |=> rd_data_o == $past(cfg); endproperty
    property p_pin;
        $changed(second_irq_pin_o) |-> $past(sample_valid_i || req_i.wr || req_i.rd);
    endproperty
    property p_awk; clk_en_i && !low_power_i |=> awake_o; endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    a_unm: assert property (p_unm) else $error("unmapped read not zero");
    a_dur: assert property (p_dur) else $error("duration bit 7 set");
    a_src: assert property (p_src) else $error("source bit 7 set");
    a_clr: assert property (p_clr) else $error("pin active after read");
    a_cfg: assert property (p_cfg) else $error("config value wrong");
    a_pin: assert property (p_pin) else $error("pin moved without cause");
    a_awk: assert property (p_awk) else $error("asleep outside low power");
endmodule : motion_irq_properties
bind motion_irq motion_irq_properties u_motion_irq_properties (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .clk_en_i(clk_en_i), .req_i(req_i),
    .rd_data_o(rd_data_o), .boot_done_i(boot_done_i), .low_power_i(low_power_i),
    .sample_valid_i(sample_valid_i), .second_irq_pin_o(second_irq_pin_o), .awake_o(awake_o));

/* motion_irq_host.sv */
// Host model driving the register strobe port.
// Assumes read data stand the cycle after the read.
`timescale 1ns/1ns
module motion_irq_host (
    input wire logic clk_i,
    output motion_irq_pkg::reg_req_t req_o,
    input wire logic [7:0] rd_data_i
);
    initial req_o = '0;
    // One access; released data is inverted so stale values never look valid.
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
        output logic [7:0] q);
        @(posedge clk_i);
        req_o <= {a, d, w, !w};
        @(posedge clk_i);
        req_o <= {a, ~d, 2'b00};
        #1 q = rd_data_i;
    endtask : acc
endmodule : motion_irq_host

/* motion_irq_tb.sv */
// Bench for motion_irq: registers, generator modes, taps and wake.
// Assumes motion_irq_host as the register master.
`timescale 1ns/1ns
`include "motion_irq_params.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin error_cnt++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module motion_irq_tb;
    logic clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic boot = 1'b0;
    logic lp = 1'b0;
    logic sv = 1'b0;
    logic ce = 1'b1;
    motion_irq_pkg::accel_sample_t smp = '0;
    motion_irq_pkg::reg_req_t req;
    logic [7:0] rdd;
    logic [7:0] q;
    logic p2, pt, awk;
    int error_cnt = 0;
    int compares = 0;
    // Readable bits of 0x33 to 0x41 after writing all ones before boot.
    logic [7:0] msk [15] = '{8'h7F, 8'h00, 8'h00, 8'h7F, 8'h7F, 8'h3F, 8'h00, 8'hFF,
        8'h7F, 8'hFF, 8'hFF, 8'h7F, 8'hFF, 8'h07, 8'h00};
    always #5 clk_i = ~clk_i;
    motion_irq u_motion_irq (.clk_i(clk_i), .arst_n_i(arst_n_i), .clk_en_i(ce),
        .req_i(req), .rd_data_o(rdd), .boot_done_i(boot), .low_power_i(lp),
        .sample_valid_i(sv), .sample_i(smp), .second_irq_pin_o(p2),
        .tap_irq_pin_o(pt), .awake_o(awk));
    motion_irq_host u_motion_irq_host (.clk_i(clk_i), .req_o(req), .rd_data_i(rdd));
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        u_motion_irq_host.acc(1'b1, a, d, q);
    endtask : wr
    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        u_motion_irq_host.acc(1'b0, a, 8'h00, q);
        `CHK(q, e)
    endtask : rc
    // One sample pulse; the inputs are scrambled once it is taken.
    task automatic s(input logic [7:0] x, input logic [7:0] y);
        @(posedge clk_i);
        sv <= 1'b1;
        smp <= {8'h00, y, x};
        @(posedge clk_i);
        sv <= 1'b0;
        smp <= ~{8'h00, y, x};
        #1;
    endtask : s
    task automatic t_regs;
        for (int i = 0; i < 15; i++)
        begin
            rc(8'h33 + 8'(i), 8'h00);
            wr(8'h33 + 8'(i), 8'hFF);
            rc(8'h33 + 8'(i), msk[i]);
            wr(8'h33 + 8'(i), 8'h00);
        end
    endtask : t_regs
    task automatic t_gen2;
        wr(`ADDR_GEN2_CONFIG, 8'h02);
        wr(`ADDR_GEN2_THRESHOLD, 8'h10);
        wr(`ADDR_GEN2_DURATION, 8'h03);
        repeat (2) s(8'h20, 8'h00);
        s(8'h00, 8'h00);
        repeat (3) s(8'h20, 8'h00);
        `CHK(p2, 1'b0)
        s(8'h20, 8'h00);
        `CHK(p2, 1'b1)
        rc(`ADDR_GEN2_SOURCE, 8'h42);
        `CHK(p2, 1'b0)
        wr(`ADDR_GEN2_DURATION, 8'h00);
        s(8'h00, 8'h00);
        s(8'h20, 8'h00);
        `CHK(p2, 1'b1)
        wr(`ADDR_IRQ_CONTROL, 8'h01);
        s(8'h00, 8'h00);
        rc(`ADDR_GEN2_SOURCE, 8'h42);
        rc(`ADDR_GEN2_SOURCE, 8'h00);
        wr(`ADDR_IRQ_CONTROL, 8'h04);
        `CHK({p2, pt}, 2'b11)
        wr(`ADDR_IRQ_CONTROL, 8'h00);
    endtask : t_gen2
    task automatic t_mode;
        wr(`ADDR_GEN2_CONFIG, 8'h42);
        s(8'h00, 8'h00);
        s(8'h20, 8'h00);
        `CHK(p2, 1'b1)
        s(8'h20, 8'h00);
        `CHK(p2, 1'b0)
        wr(`ADDR_GEN2_CONFIG, 8'hC2);
        repeat (2) s(8'h20, 8'h00);
        `CHK(p2, 1'b1)
        ce <= 1'b0;
        s(8'h00, 8'h00);
        `CHK(p2, 1'b1)
        ce <= 1'b1;
        wr(`ADDR_GEN2_CONFIG, 8'h86);
        s(8'h20, 8'h20);
        `CHK(p2, 1'b0)
        s(8'h20, 8'h00);
        `CHK(p2, 1'b1)
        wr(`ADDR_GEN2_CONFIG, 8'h00);
        s(8'h00, 8'h00);
    endtask : t_mode
    task automatic t_tap;
        wr(`ADDR_TAP_CONFIG, 8'h01);
        wr(`ADDR_TAP_THRESHOLD, 8'h10);
        wr(`ADDR_TAP_TIME_LIMIT, 8'h02);
        wr(`ADDR_TAP_LATENCY, 8'h02);
        s(8'h20, 8'h00);
        s(8'h00, 8'h00);
        repeat (2) @(posedge clk_i);
        repeat (2) s(8'h00, 8'h00);
        `CHK(pt, 1'b1)
        s(8'h00, 8'h00);
        `CHK(pt, 1'b0)
        s(8'h00, 8'h00);
        wr(`ADDR_TAP_THRESHOLD, 8'h90);
        s(8'hE0, 8'h00);
        repeat (6) s(8'h00, 8'h00);
        `CHK(pt, 1'b1)
        rc(`ADDR_TAP_SOURCE, 8'h59);
        `CHK(pt, 1'b0)
    endtask : t_tap
    task automatic t_wake;
        wr(`ADDR_WAKE_THRESHOLD, 8'h10);
        wr(`ADDR_WAKE_DURATION, 8'h01);
        lp <= 1'b1;
        repeat (8) s(8'h00, 8'h00);
        `CHK(awk, 1'b1)
        s(8'h00, 8'h00);
        `CHK(awk, 1'b0)
        s(8'h20, 8'h00);
        `CHK(awk, 1'b1)
        lp <= 1'b0;
    endtask : t_wake
    task automatic print_verdict;
        if (error_cnt == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : print_verdict
    // Watchdog: a hang counts as a mismatch.
    initial
    begin
        #1000000;
        error_cnt++;
        print_verdict;
    end
    initial
    begin
        repeat (10) @(posedge clk_i);
        arst_n_i <= 1'b1;
        t_regs;
        boot <= 1'b1;
        wr(`ADDR_GEN2_CONFIG, 8'h2A);
        rc(`ADDR_GEN2_CONFIG, 8'h2A);
        t_gen2;
        t_mode;
        t_tap;
        t_wake;
        print_verdict;
    end
endmodule : motion_irq_tb
